// ===== logic/sfr_device.sv
// flash side reset sequencer: power-on window and line3 restart
// assumes link pins are asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module sfr_device
   import sfr_pkg::*;
#(
   parameter int POWER_ON_CYCLES   = POWER_ON_CYC,
   parameter int PULSE_HOLD_CYCLES = PULSE_HOLD_CYC
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   sfr_link_if.dev   link,
   input  wire logic quad_enable_bit_i,
   input  wire logic line3_restart_enable_bit_i,
   input  wire logic por_ok_i,
   input  wire logic sw_reset_i,
   input  wire logic quad_read_end_i,
   output logic      in_reset_o,
   output logic      regs_reinit_o,
   output logic      ready_o
);
   import sfr_pkg::*;

   initial begin
      if (POWER_ON_CYCLES < 1 || POWER_ON_CYCLES >= 2**CNT_W ||
          PULSE_HOLD_CYCLES < 1 || PULSE_HOLD_CYCLES >= 2**CNT_W)
         $error("sfr_device: counts out of range");
   end

   // ----------------------------------------------------------------
   // pin synchronisers, three stages, change counts when 2 and 3 agree
   // ----------------------------------------------------------------
   logic [2:0] sel_s, l3_s, next_sel_s, next_l3_s;
   logic       sel_q, l3_q, next_sel_q, next_l3_q;
   always_comb begin
      next_sel_s = {sel_s[1:0], link.sel_n};
      next_l3_s  = {l3_s[1:0], link.shared_line3_restart_pin};
      next_sel_q = (sel_s[1] == sel_s[2]) ? sel_s[2] : sel_q;
      next_l3_q  = (l3_s[1] == l3_s[2]) ? l3_s[2] : l3_q;
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_s <= 3'h7;
         l3_s  <= 3'h7;
         sel_q <= 1'b1;
         l3_q  <= 1'b1;
      end else begin
         sel_s <= next_sel_s;
         l3_s  <= next_l3_s;
         sel_q <= next_sel_q;
         l3_q  <= next_l3_q;
      end
   end

   // ----------------------------------------------------------------
   // select-high timer and restart qualification
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] sel_hi_cnt, next_sel_hi_cnt;
   logic             sel_hi_long, restart_lvl, quad_restart;
   always_comb begin
      next_sel_hi_cnt = sel_hi_cnt;
      if (!sel_q)
         next_sel_hi_cnt = '0;
      else if (sel_hi_cnt < CNT_W'(SELECT_HIGH_CYC))
         next_sel_hi_cnt = sel_hi_cnt + 1'b1;
      sel_hi_long  = (sel_hi_cnt >= CNT_W'(SELECT_HIGH_CYC));
      quad_restart = line3_restart_enable_bit_i && quad_enable_bit_i;
      // pin is data while selected in quad mode
      restart_lvl = !l3_q &&
         (!quad_enable_bit_i || (quad_restart && sel_q && sel_hi_long));
   end

   // ----------------------------------------------------------------
   // reset state machine
   // ----------------------------------------------------------------
   sfr_dev_state_type state, next_state;
   logic [CNT_W-1:0]  cnt, next_cnt;
   logic [CNT_W-1:0]  low_cnt, next_low_cnt;
   logic              por_done, next_por_done;
   logic              reinit, next_reinit;
   logic              l3_drv, next_l3_drv;
   logic              l3_oe, next_l3_oe;

   always_comb begin
      next_state    = state;
      next_cnt      = cnt;
      next_low_cnt  = low_cnt;
      next_por_done = por_done;
      next_reinit   = 1'b0;
      next_l3_drv   = 1'b1;
      next_l3_oe    = 1'b0;
      // low-time measure of a qualified restart level
      if (restart_lvl && low_cnt < CNT_W'(RESTART_PULSE_CYC))
         next_low_cnt = low_cnt + 1'b1;
      else if (!restart_lvl)
         next_low_cnt = '0;             // short pulse forgotten
      case (state)
         SFR_POWER_ON, SFR_FULL_POR: begin
            if (cnt >= CNT_W'(POWER_ON_CYCLES - 1)) begin
               next_cnt      = '0;
               next_por_done = por_ok_i;
               // still low at end keeps reset held
               next_state = !l3_q ? SFR_HELD : SFR_READY;
               next_reinit = 1'b1;
            end else begin
               next_cnt = cnt + 1'b1;
            end
            next_low_cnt = '0;
         end
         SFR_HELD: begin
            if (l3_q)
               next_state = SFR_READY;
            next_low_cnt = '0;
         end
         SFR_READY: begin
            // end of quad read drives line3 high one cycle
            if (quad_read_end_i) begin
               next_l3_drv = 1'b1;
               next_l3_oe  = 1'b1;
            end
            if (low_cnt >= CNT_W'(RESTART_PULSE_CYC)) begin
               next_cnt = '0;
               next_state = por_done ? SFR_RESTART : SFR_FULL_POR;
               next_reinit = por_done;
            end else if (sw_reset_i) begin
               next_reinit = 1'b1;          // pin state irrelevant unless a restart completes in the same cycle
            end
         end
         SFR_RESTART: begin
            if (cnt >= CNT_W'(PULSE_HOLD_CYCLES - RESTART_PULSE_CYC))
               next_state = l3_q ? SFR_READY : SFR_HELD;
            else
               next_cnt = cnt + 1'b1;
            next_low_cnt = '0;
         end
         default: next_state = SFR_POWER_ON;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state      <= SFR_POWER_ON;
         cnt        <= '0;
         low_cnt    <= '0;
         sel_hi_cnt <= '0;
         por_done   <= 1'b0;
         reinit     <= 1'b0;
         l3_drv     <= 1'b1;
         l3_oe      <= 1'b0;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         low_cnt    <= next_low_cnt;
         sel_hi_cnt <= next_sel_hi_cnt;
         por_done   <= next_por_done;
         reinit     <= next_reinit;
         l3_drv     <= next_l3_drv;
         l3_oe      <= next_l3_oe;
      end
   end

   // outputs; line3 released whenever reset is active, except the first SFR_RESTART or SFR_FULL_POR cycle when quad_read_end_i met the restart
   assign link.l3_dev_o  = l3_drv;
   assign link.l3_dev_oe = l3_oe;
   assign in_reset_o     = (state != SFR_READY);
   assign ready_o        = (state == SFR_READY);
   assign regs_reinit_o  = reinit;
endmodule
`default_nettype wire

// ===== logic/sfr_pkg.sv
// constants and types shared by both ends of the flash reset link
// assumes a 100 MHz system clock on each end
package sfr_pkg;
   // ----------------------------------------------------------------
   // timing figures and derived cycle counts
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS       = 10;
   localparam int POWER_ON_WINDOW_US  = 300;
   localparam int RESET_PULSE_HOLD_US = 35;
   localparam int RESTART_PULSE_NS    = 200;
   localparam int RESTART_PULSE_MAX_US = 5;
   localparam int RESET_SETUP_NS      = 50;
   localparam int RESET_HOLD_NS       = 50;
   localparam int SELECT_HIGH_NS      = 20;
   // longest times round down, least times round up
   localparam int POWER_ON_CYC =
      POWER_ON_WINDOW_US * 1000 / CLK_PERIOD_NS;
   localparam int PULSE_HOLD_CYC =
      RESET_PULSE_HOLD_US * 1000 / CLK_PERIOD_NS;
   localparam int RESTART_PULSE_CYC =
      (RESTART_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTART_MAX_CYC =
      RESTART_PULSE_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int RESET_SETUP_CYC =
      (RESET_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_HOLD_CYC =
      (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELECT_HIGH_CYC =
      (SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   // link clock divider half period, in system clocks
   localparam int LINK_HALF_CYC = 4;

   // device reset states
   typedef enum logic [2:0] {
      SFR_POWER_ON = 3'b000,
      SFR_HELD     = 3'b001,
      SFR_READY    = 3'b010,
      SFR_RESTART  = 3'b011,
      SFR_FULL_POR = 3'b100
   } sfr_dev_state_type;

   // host sequencer states
   typedef enum logic [2:0] {
      SFRH_WAIT_PU = 3'b000,
      SFRH_IDLE    = 3'b001,
      SFRH_XFER    = 3'b010,
      SFRH_DRIVE_HI = 3'b011,
      SFRH_PULSE   = 3'b100,
      SFRH_HOLD    = 3'b101,
      SFRH_SETUP   = 3'b110
   } sfr_host_state_type;
endpackage

// ===== logic/sfr_link_if.sv
// pins between the flash controller and the flash reset logic
// assumes both ends sit on the same bench; resolves line3 here
`timescale 1ns/1ns
`default_nettype none
interface sfr_link_if;
   logic sel_n;        // chip select, low active
   logic sck;          // serial clock from host
   logic l3_host_o;    // host drive value on line3
   logic l3_host_oe;
   logic l3_dev_o;     // device drive value on line3
   logic l3_dev_oe;
   wire  shared_line3_restart_pin;
   // pull-up when nobody drives
   assign shared_line3_restart_pin =
      l3_host_oe ? l3_host_o : (l3_dev_oe ? l3_dev_o : 1'b1);
   modport host (output sel_n, output sck, output l3_host_o,
                 output l3_host_oe, input shared_line3_restart_pin);
   modport dev (input sel_n, input sck, output l3_dev_o,
                output l3_dev_oe, input shared_line3_restart_pin);
endinterface
`default_nettype wire

// ===== logic/sfr_host.sv
// controller side: select, link clock, restart pulses on line3
// assumes the device end sits across sfr_link_if
`timescale 1ns/1ns
`default_nettype none
module sfr_host
   import sfr_pkg::*;
#(
   parameter int POWER_ON_CYCLES   = POWER_ON_CYC,
   parameter int PULSE_HOLD_CYCLES = PULSE_HOLD_CYC,
   parameter int PULSE_CYCLES      = RESTART_PULSE_CYC + 10
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   sfr_link_if.host  link,
   input  wire logic xfer_req_i,
   input  wire logic xfer_quad_wr_i,
   input  wire logic restart_req_i,
   output logic      busy_o,
   output logic      ready_o
);
   import sfr_pkg::*;

   localparam int HOLD_CYC_EFF =
      (PULSE_HOLD_CYCLES - PULSE_CYCLES > RESET_HOLD_CYC) ?
      PULSE_HOLD_CYCLES - PULSE_CYCLES : RESET_HOLD_CYC;

   initial begin
      if (PULSE_CYCLES <= RESTART_PULSE_CYC ||
          PULSE_CYCLES > RESTART_MAX_CYC ||
          POWER_ON_CYCLES >= 2**CNT_W)
         $error("sfr_host: pulse width out of range");
   end

   sfr_host_state_type state, next_state;
   logic [CNT_W-1:0]   cnt, next_cnt;
   logic [2:0]         div, next_div;
   logic               sck, next_sck, sel_n, next_sel_n;
   logic               l3_o, next_l3_o, l3_oe, next_l3_oe;
   logic               quad_wr, next_quad_wr;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state   = state;
      next_cnt     = cnt + 1'b1;
      next_sel_n   = 1'b1;
      next_l3_o    = 1'b1;
      next_l3_oe   = 1'b0;
      next_quad_wr = quad_wr;
      next_div     = div + 1'b1;
      next_sck     = sck;
      if (div == 3'(LINK_HALF_CYC - 1)) begin
         next_div = '0;
         next_sck = !sck;
      end
      case (state)
         SFRH_WAIT_PU: begin
            // no select while device powers up
            if (cnt >= CNT_W'(POWER_ON_CYCLES)) begin
               next_state = SFRH_SETUP;
               next_cnt   = '0;
            end
         end
         SFRH_SETUP: begin
            if (cnt >= CNT_W'(RESET_SETUP_CYC))
               next_state = SFRH_IDLE;
         end
         SFRH_IDLE: begin
            // select-high time keeps counting after a transfer ends
            next_cnt = cnt;
            if (cnt < CNT_W'(SELECT_HIGH_CYC))
               next_cnt = cnt + 1'b1;
            if (restart_req_i) begin
               next_state = SFRH_PULSE;
               next_cnt   = '0;
               next_l3_o  = 1'b0;
               next_l3_oe = 1'b1;
            end else if (xfer_req_i &&
                         cnt >= CNT_W'(SELECT_HIGH_CYC)) begin
               next_state   = SFRH_XFER;
               next_cnt     = '0;
               next_sel_n   = 1'b0;
               next_quad_wr = xfer_quad_wr_i;
            end
         end
         SFRH_XFER: begin
            next_sel_n = 1'b0;
            next_l3_oe = quad_wr;
            if (!xfer_req_i) begin
               next_state = SFRH_DRIVE_HI;
               next_cnt   = '0;
               next_sel_n = 1'b1;
               next_l3_oe = quad_wr;
            end
         end
         SFRH_DRIVE_HI: begin
            next_state = SFRH_IDLE;
            next_cnt   = '0;
         end
         SFRH_PULSE: begin
            next_l3_o  = 1'b0;
            next_l3_oe = 1'b1;
            if (cnt >= CNT_W'(PULSE_CYCLES - 1)) begin
               next_state = SFRH_HOLD;
               next_cnt   = '0;
               next_l3_oe = 1'b1;
            end
         end
         SFRH_HOLD: begin
            if (cnt >= CNT_W'(HOLD_CYC_EFF))
               next_state = SFRH_SETUP;
            if (cnt >= CNT_W'(HOLD_CYC_EFF))
               next_cnt = '0;
         end
         default: next_state = SFRH_WAIT_PU;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state   <= SFRH_WAIT_PU;
         cnt     <= '0;
         div     <= '0;
         sck     <= 1'b0;
         sel_n   <= 1'b1;
         l3_o    <= 1'b1;
         l3_oe   <= 1'b0;
         quad_wr <= 1'b0;
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         div     <= next_div;
         sck     <= next_sck;
         sel_n   <= next_sel_n;
         l3_o    <= next_l3_o;
         l3_oe   <= next_l3_oe;
         quad_wr <= next_quad_wr;
      end
   end

   assign link.sel_n      = sel_n;
   assign link.sck        = sck;
   assign link.l3_host_o  = l3_o;
   assign link.l3_host_oe = l3_oe;
   assign busy_o  = (state != SFRH_IDLE);
   assign ready_o = (state == SFRH_IDLE);
endmodule
`default_nettype wire

// ===== sim/sfr_link_sva.sv
// checker for the select and line3 wires of the reset link
// assumes one system clock and the async low reset of both ends
`timescale 1ns/1ns
`default_nettype none
module sfr_link_sva
   import sfr_pkg::*;
#(
   parameter int POWER_ON_CYCLES   = POWER_ON_CYC,
   parameter int PULSE_HOLD_CYCLES = PULSE_HOLD_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic sel_n,
   input wire logic l3_host_o,
   input wire logic l3_host_oe,
   input wire logic l3_dev_o,
   input wire logic l3_dev_oe,
   input wire logic shared_line3_restart_pin
);
   // ---------------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] pu_cnt, lo_cnt, hi_cnt, rf_cnt;
   logic [CNT_W-1:0] next_pu_cnt, next_lo_cnt, next_hi_cnt, next_rf_cnt;
   wire logic        pin;
   assign pin = shared_line3_restart_pin;

   // saturating except lo_cnt, so long idle stretches never wrap to small values
   always_comb begin
      next_pu_cnt = (pu_cnt < POWER_ON_CYCLES) ? pu_cnt + 1'b1 : pu_cnt;
      next_lo_cnt = (pin || !sel_n) ? '0 : lo_cnt + 1'b1;
      next_hi_cnt = !pin ? '0 : (&hi_cnt ? hi_cnt : hi_cnt + 1'b1);
      next_rf_cnt = (!pin && sel_n && lo_cnt == '0) ? '0 :
                    (&rf_cnt ? rf_cnt : rf_cnt + 1'b1);
   end

   // registers only
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pu_cnt <= '0;
         lo_cnt <= '0;
         hi_cnt <= '1;
         rf_cnt <= '1;
      end else begin
         pu_cnt <= next_pu_cnt;
         lo_cnt <= next_lo_cnt;
         hi_cnt <= next_hi_cnt;
         rf_cnt <= next_rf_cnt;
      end
   end

   // ---------------------------------------------------------------
   // wire relations
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   property p_sel_power_on;
      pu_cnt < POWER_ON_CYCLES |-> sel_n;
   endproperty
   a_sel_power_on: assert property (p_sel_power_on)
      else $error("select low inside power-on window");
   property p_pulse_max;
      lo_cnt <= RESTART_MAX_CYC;
   endproperty
   a_pulse_max: assert property (p_pulse_max)
      else $error("restart pulse too long");
   property p_setup;
      $fell(pin) && sel_n |-> hi_cnt >= RESET_SETUP_CYC;
   endproperty
   a_setup: assert property (p_setup)
      else $error("line3 high too short before restart");
   property p_hold;
      $rose(pin) && lo_cnt > 1 |-> sel_n [*5];
   endproperty
   a_hold: assert property (p_hold)
      else $error("select low inside hold time");
   property p_reset_span;
      $fell(sel_n) |-> rf_cnt >= PULSE_HOLD_CYCLES;
   endproperty
   a_reset_span: assert property (p_reset_span)
      else $error("select low before reset period ended");
   property p_sel_gap;
      $rose(sel_n) |-> sel_n [*2];
   endproperty
   a_sel_gap: assert property (p_sel_gap)
      else $error("select high gap too short");
   property p_host_release;
      $fell(l3_host_oe) && !$past(sel_n, 2) |-> $past(l3_host_o);
   endproperty
   a_host_release: assert property (p_host_release)
      else $error("host released line3 while low");
   property p_dev_release;
      $fell(l3_dev_oe) |-> $past(l3_dev_o);
   endproperty
   a_dev_release: assert property (p_dev_release)
      else $error("device released line3 while low");
endmodule
`default_nettype wire

// ===== sim/sfr_tb.sv
// bench: host and device face each other; a second device is driven
// assumes the pullup of the link interface and shortened windows
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import sfr_pkg::*;
   localparam int PU = 200;
   localparam int PH = 100;
   logic clk_i = 1'b0, nrst_i = 1'b0, xreq = 1'b0, xqw = 1'b0;
   logic rreq = 1'b0, qe = 1'b0, re = 1'b0, pok = 1'b1, swr = 1'b0;
   logic qre = 1'b0, s2 = 1'b1, p2 = 1'b1;
   logic ir1, rr1, rd1, ir2, rr2, rd2, hb, hr;
   int   err_count = 0, samples_checked = 0, cyc = 0;
   int   n1 = 0, n2 = 0, nq = 0, k;

   // ---------------------------------------------------------------
   // links and ends
   // ---------------------------------------------------------------
   sfr_link_if link();
   sfr_link_if link2();
   // second link: bench stands in for the host, link clock still
   assign link2.sel_n = s2;
   assign link2.sck = 1'b0;
   assign link2.l3_host_o = p2;
   assign link2.l3_host_oe = 1'b1;
   sfr_host #(.POWER_ON_CYCLES(PU), .PULSE_HOLD_CYCLES(PH)) sfr_host_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .link(link), .xfer_req_i(xreq),
      .xfer_quad_wr_i(xqw), .restart_req_i(rreq), .busy_o(hb), .ready_o(hr));
   sfr_device #(.POWER_ON_CYCLES(PU), .PULSE_HOLD_CYCLES(PH))
   sfr_device_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link),
      .quad_enable_bit_i(qe), .line3_restart_enable_bit_i(re),
      .por_ok_i(pok), .sw_reset_i(swr), .quad_read_end_i(qre),
      .in_reset_o(ir1), .regs_reinit_o(rr1), .ready_o(rd1));
   sfr_device #(.POWER_ON_CYCLES(PU), .PULSE_HOLD_CYCLES(PH))
   sfr_device_inst_2 (.clk_i(clk_i), .nrst_i(nrst_i), .link(link2),
      .quad_enable_bit_i(qe), .line3_restart_enable_bit_i(re),
      .por_ok_i(pok), .sw_reset_i(1'b0), .quad_read_end_i(1'b0),
      .in_reset_o(ir2), .regs_reinit_o(rr2), .ready_o(rd2));
   sfr_link_sva #(.POWER_ON_CYCLES(PU), .PULSE_HOLD_CYCLES(PH))
   sfr_link_sva_inst (.clk_i(clk_i), .nrst_i(nrst_i), .sel_n(link.sel_n),
      .l3_host_o(link.l3_host_o), .l3_host_oe(link.l3_host_oe),
      .l3_dev_o(link.l3_dev_o), .l3_dev_oe(link.l3_dev_oe),
      .shared_line3_restart_pin(link.shared_line3_restart_pin));

   // ---------------------------------------------------------------
   // clock, event counts, hang guard
   // ---------------------------------------------------------------
   always #5 clk_i = ~clk_i;
   // counting pulses avoids racing a one-cycle output
   always @(posedge clk_i) begin
      cyc++;
      if (rr1 === 1'b1) n1++;
      if (rr2 === 1'b1) n2++;
      if (link.l3_dev_oe === 1'b1 && link.l3_dev_o === 1'b1) nq++;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task chk(input logic c, input string m);
      samples_checked++;
      if (c !== 1'b1) begin
         $display("CHECK FAILED %0t %s", $time, m);
         err_count++;
      end
   endtask
   task pulse2(input int n);
      p2 = 1'b0;
      wt(n);
      p2 = 1'b1;
   endtask
   task power_up(input logic ok);
      pok = ok;
      nrst_i = 1'b0;
      wt(20);
      nrst_i = 1'b1;
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // low inside the window must neither reset nor delay the device
   task t_power_on;
      power_up(1'b1);
      wt(50);
      pulse2(40);
      wt(PU - 80);
      chk(rd1 === 1'b1 && rd2 === 1'b1, "not ready after window");
      // only the window-end register init, nothing from the low
      chk(n2 == 1 && hr === 1'b1, "low in window acted");
      $display("test power_on done");
   endtask
   // low across the window end keeps the device held
   task t_held;
      power_up(1'b1);
      wt(100);
      p2 = 1'b0;
      wt(PU);
      chk(ir2 === 1'b1 && rd1 === 1'b1, "not held at window end");
      p2 = 1'b1;
      wt(PH + 30);
      chk(rd2 === 1'b1, "still held after release");
      $display("test held done");
   endtask
   task t_host_restart;
      k = n1;
      rreq = 1'b1;
      wt(1);
      rreq = 1'b0;
      wt(60);
      chk(n1 == k + 1, "no reinit on restart");
      chk(ir1 === 1'b1 && link.l3_dev_oe === 1'b0, "not in reset");
      wt(PH);
      chk(rd1 === 1'b1 && hr === 1'b1, "reset did not complete");
      $display("test host_restart done");
   endtask
   task t_short;
      k = n2;
      pulse2(10);
      wt(40);
      chk(n2 == k && rd2 === 1'b1, "short pulse acted");
      $display("test short done");
   endtask
   task gate(input logic q, input logic r, input logic sl, input int e);
      qe = q;
      re = r;
      s2 = !sl;
      wt(10);
      k = n2;
      pulse2(40);
      s2 = 1'b1;
      wt(PH + 30);
      chk(n2 == k + e && rd2 === 1'b1, "qualification wrong");
   endtask
   task t_misc;
      k = n1;
      swr = 1'b1;
      wt(1);
      swr = 1'b0;
      wt(3);
      chk(n1 == k + 1 && ir1 === 1'b0, "software reset wrong");
      k = nq;
      qre = 1'b1;
      wt(1);
      qre = 1'b0;
      wt(3);
      chk(nq > k, "line3 not driven high at read end");
      xqw = 1'b1;
      xreq = 1'b1;
      wt(8);
      chk(link.sel_n === 1'b0, "transfer not started");
      xreq = 1'b0;
      wt(2);
      xreq = 1'b1;
      wt(8);
      chk(link.sel_n === 1'b0, "second transfer refused");
      xreq = 1'b0;
      wt(10);
      chk(link.sel_n === 1'b1 && link.l3_host_oe === 1'b0 &&
          link.shared_line3_restart_pin === 1'b1, "end state");
      $display("test misc done");
   endtask
   // failed power-on: restart must rerun the whole window
   task t_fail;
      power_up(1'b0);
      wt(PU + 10);
      pulse2(40);
      wt(PH + 30);
      chk(ir2 === 1'b1, "warm reset after failed power-on");
      wt(PU);
      chk(rd2 === 1'b1, "full window did not finish");
      $display("test fail done");
   endtask

   initial begin
      t_power_on();
      t_held();
      t_host_restart();
      t_short();
      gate(1'b1, 1'b1, 1'b1, 0);
      gate(1'b1, 1'b0, 1'b0, 0);
      gate(1'b1, 1'b1, 1'b0, 1);
      gate(1'b0, 1'b0, 1'b1, 1);
      $display("test gate done");
      t_misc();
      t_fail();
      finish_test();
   end
endmodule
`default_nettype wire
